// file: shared/regmap_defines.svh
// Purpose: Offsets, presets, field positions and timing counts of the reader register bank
// Assumes: Byte registers on a 5-bit register address
// Notes:   Included by bare name; definitions only
`ifndef REGMAP_DEFINES_SVH
`define REGMAP_DEFINES_SVH

// ==========================================================
// Register offsets
`define ADDR_POWER_RF_CONTROL     5'h00
`define ADDR_PROTOCOL_SELECT      5'h01
`define ADDR_TYPE_B_TX_OPTIONS    5'h02
`define ADDR_TYPE_A_HIGH_RATE     5'h03
`define ADDR_TX_DELAY_HIGH        5'h04
`define ADDR_TX_DELAY_LOW         5'h05
`define ADDR_TX_PULSE_WIDTH       5'h06
`define ADDR_RX_TIMEOUT_WAIT      5'h07
`define ADDR_RX_START_DELAY       5'h08
`define ADDR_MOD_CLKOUT_CTRL      5'h09
`define ADDR_RX_TUNING            5'h0a
`define ADDR_REGULATOR_IO_CTRL    5'h0b
`define ADDR_INTERRUPT_FLAGS      5'h0c
`define ADDR_COLLISION_MASK_CTRL  5'h0d
`define ADDR_COLLISION_LOCATION   5'h0e
`define ADDR_SIGNAL_LEVEL_OSC     5'h0f
`define ADDR_EXTRA_FUNCTION_A     5'h10
`define ADDR_EXTRA_FUNCTION_B     5'h11
`define ADDR_FIFO_THRESHOLD       5'h14
`define ADDR_FACTORY_TEST_A       5'h1a
`define ADDR_FACTORY_TEST_B       5'h1b
`define ADDR_QUEUE_FILL_STATE     5'h1c
`define ADDR_TX_COUNT_FIRST       5'h1d
`define ADDR_TX_COUNT_SECOND      5'h1e
`define ADDR_QUEUE_DATA_PORT      5'h1f

// ==========================================================
// Preset values
`define RST_POWER_RF_CONTROL      8'h01
`define RST_PROTOCOL_SELECT       8'h02
`define RST_TYPE_B_TX_OPTIONS     8'h00
`define RST_TYPE_A_HIGH_RATE      8'h00
`define RST_TX_DELAY_HIGH         8'hc1
`define RST_TX_DELAY_LOW          8'hc1
`define RST_TX_PULSE_WIDTH        8'h00
`define RST_RX_TIMEOUT_WAIT       8'h0e
`define RST_RX_START_DELAY        8'h07
`define RST_MOD_CLKOUT_CTRL       8'h91
`define RST_RX_TUNING             8'h10
`define RST_REGULATOR_IO_CTRL     8'h87
`define RST_COLLISION_MASK_CTRL   8'h3e
`define RST_ZERO                  8'h00

// ==========================================================
// Field positions and masks
`define PRC_STANDBY_BIT           7
`define PRC_DIRECT_BIT            6
`define PRC_CARRIER_ON_BIT        5
`define PRC_POWER_HALF_BIT        4
`define PRC_AUX_INPUT_BIT         3
`define PRC_FORCED_RX_BIT         1
`define PRC_SUPPLY_RANGE_BIT      0
`define PRC_WRITE_MASK            8'hfb
`define PSEL_DIRECT_VARIANT_BIT   6
`define MOD_CLKDIV_MASK           8'h30
`define SUBSET_FIRST              5'h02
`define SUBSET_LAST               5'h0b

// ==========================================================
// Timing
`define CLK_SYS_MHZ               200
`define STBY_WAKE_US              100
`define WAKE_CYCLES_DEFAULT       (`STBY_WAKE_US * `CLK_SYS_MHZ)

`endif

// file: shared/regmap_pkg.sv
// Purpose: Types shared by the reader register bank
// Assumes: Nothing beyond the defines header
// Notes:   Constants live in regmap_defines.svh
package regmap_pkg;

	typedef logic [4:0] reg_addr_t;
	typedef logic [7:0] byte_t;

	typedef enum logic [1:0] {
		FRAME_AUTO,
		FRAME_RAW_AFE,
		FRAME_CUSTOM
	} frame_mode_e;

	typedef enum logic [1:0] {
		WAKE_STANDBY,
		WAKE_COUNTING,
		WAKE_READY
	} wake_state_e;

endpackage

// file: shared/power_if.sv
// Purpose: Standby request and full-operation status between bank and wake timer
// Assumes: Single clock domain
// Notes:   No clocking block
`timescale 1ns/100ps
`default_nettype none
interface power_if;
	logic standby;
	logic ready;
	modport ctrl  (output standby, input ready);
	modport timer (input standby, output ready);
endinterface
`default_nettype wire

// file: src/wake_timer.sv
// Purpose: Counts the standby exit time before full operation is reported
// Assumes: standby comes from a flip-flop of the bank
// Notes:   Clocks and regulators keep running in standby, so only a timer is needed
`timescale 1ns/100ps
`default_nettype none
`include "regmap_defines.svh"
module wake_timer #(
	parameter int unsigned WAKE_CYCLES = `WAKE_CYCLES_DEFAULT
) (
	input  wire logic clk_sys_i,
	input  wire logic rstn_i,
	input  wire logic preset_i,
	power_if.timer    pwr
);
	import regmap_pkg::*;

	wake_state_e state_reg;
	logic [15:0] count_reg;

	// ==========================================================
	// Wake sequencing
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= WAKE_COUNTING;
			count_reg <= 16'h0000;
		end else if (preset_i || pwr.standby) begin
			state_reg <= pwr.standby ? WAKE_STANDBY : WAKE_COUNTING;
			count_reg <= 16'h0000;
		end else begin
			unique case (state_reg)
				WAKE_STANDBY: begin
					state_reg <= WAKE_COUNTING;
				end
				WAKE_COUNTING: begin
					if (count_reg >= 16'(WAKE_CYCLES - 1)) begin
						state_reg <= WAKE_READY;
					end else begin
						count_reg <= count_reg + 16'h0001;
					end
				end
				WAKE_READY: begin
					state_reg <= WAKE_READY;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pwr.ready <= 1'b0;
		end else begin
			pwr.ready <= (state_reg == WAKE_READY) && !pwr.standby && !preset_i;
		end
	end

endmodule
`default_nettype wire

// file: src/reader_regmap.sv
// Purpose: Register bank and power/RF control of the reader front end
// Assumes: Host accesses arrive decoded as byte read and write strobes
// Notes:   Read data appears one cycle after the read strobe
// Contract
// - Standby keeps clocks running, wakes within 100 us
// - Direct bit picks raw or custom framing
// - Carrier bit enables transmitter and receivers
// - Power bit selects half or full power
// - Input bit routes aux or main input
// - Forced bit enables receiver and oscillator
// - Bit 0 picks 5 V; bit 2 reserved
// - Subset registers 0x02 to 0x0B are read-write
// - Extra function registers read-write, preset zero
// - FIFO threshold register is read-write
// - Mask register read-write, collision register read-only
// - Flags, signal and fill registers read-only
// - Protocol write reloads subsets, keeps clock divider
// - FIFO reset clears fill and collision registers
`timescale 1ns/100ps
`default_nettype none
`include "regmap_defines.svh"
module reader_regmap #(
	parameter int unsigned WAKE_CYCLES = `WAKE_CYCLES_DEFAULT
) (
	input  wire logic                  clk_sys_i,
	input  wire logic                  rstn_i,
	input  wire logic                  chip_en_i,
	input  wire regmap_pkg::reg_addr_t reg_addr_i,
	input  wire regmap_pkg::byte_t     reg_wdata_i,
	input  wire logic                  reg_wr_i,
	input  wire logic                  reg_rd_i,
	output var  regmap_pkg::byte_t     reg_rdata_o,
	output logic                       reg_rvalid_o,
	input  wire regmap_pkg::byte_t     irq_flags_i,
	input  wire regmap_pkg::byte_t     signal_level_i,
	input  wire regmap_pkg::byte_t     collision_pos_i,
	input  wire logic                  collision_load_i,
	input  wire regmap_pkg::byte_t     fill_state_i,
	input  wire logic                  fill_load_i,
	input  wire logic                  fifo_reset_i,
	input  wire regmap_pkg::byte_t     fifo_rdata_i,
	output logic                       fifo_wr_o,
	output logic                       fifo_rd_o,
	output var  regmap_pkg::byte_t     fifo_wdata_o,
	output logic                       subset_reload_o,
	output logic                       standby_o,
	output logic                       full_op_ready_o,
	output logic                       osc_run_o,
	output logic                       regulators_on_o,
	output var  regmap_pkg::frame_mode_e frame_mode_o,
	output logic                       tx_enable_o,
	output logic                       rx_enable_o,
	output logic                       tx_osc_enable_o,
	output logic                       output_power_half_o,
	output logic                       aux_input_select_o,
	output logic                       supply_range_sel_o
);
	import regmap_pkg::*;

	// ==========================================================
	// Access type and preset decoding
	function automatic byte_t preset_value(input reg_addr_t a);
		byte_t v;
		v = `RST_ZERO;
		unique case (a)
			`ADDR_POWER_RF_CONTROL:    v = `RST_POWER_RF_CONTROL;
			`ADDR_PROTOCOL_SELECT:     v = `RST_PROTOCOL_SELECT;
			`ADDR_TYPE_B_TX_OPTIONS:   v = `RST_TYPE_B_TX_OPTIONS;
			`ADDR_TYPE_A_HIGH_RATE:    v = `RST_TYPE_A_HIGH_RATE;
			`ADDR_TX_DELAY_HIGH:       v = `RST_TX_DELAY_HIGH;
			`ADDR_TX_DELAY_LOW:        v = `RST_TX_DELAY_LOW;
			`ADDR_TX_PULSE_WIDTH:      v = `RST_TX_PULSE_WIDTH;
			`ADDR_RX_TIMEOUT_WAIT:     v = `RST_RX_TIMEOUT_WAIT;
			`ADDR_RX_START_DELAY:      v = `RST_RX_START_DELAY;
			`ADDR_MOD_CLKOUT_CTRL:     v = `RST_MOD_CLKOUT_CTRL;
			`ADDR_RX_TUNING:           v = `RST_RX_TUNING;
			`ADDR_REGULATOR_IO_CTRL:   v = `RST_REGULATOR_IO_CTRL;
			`ADDR_COLLISION_MASK_CTRL: v = `RST_COLLISION_MASK_CTRL;
			default:                   v = `RST_ZERO;
		endcase
		return v;
	endfunction

	// Mask of bits the host may write; zero marks read-only or unmapped
	function automatic byte_t write_mask(input reg_addr_t a);
		byte_t m;
		m = 8'h00;
		unique case (a)
			`ADDR_POWER_RF_CONTROL:    m = `PRC_WRITE_MASK;
			`ADDR_PROTOCOL_SELECT,
			`ADDR_TYPE_B_TX_OPTIONS,
			`ADDR_TYPE_A_HIGH_RATE,
			`ADDR_TX_DELAY_HIGH,
			`ADDR_TX_DELAY_LOW,
			`ADDR_TX_PULSE_WIDTH,
			`ADDR_RX_TIMEOUT_WAIT,
			`ADDR_RX_START_DELAY,
			`ADDR_MOD_CLKOUT_CTRL,
			`ADDR_RX_TUNING,
			`ADDR_REGULATOR_IO_CTRL:   m = 8'hff;
			`ADDR_COLLISION_MASK_CTRL: m = 8'hff;
			`ADDR_EXTRA_FUNCTION_A,
			`ADDR_EXTRA_FUNCTION_B:    m = 8'hff;
			`ADDR_FIFO_THRESHOLD:      m = 8'hff;
			`ADDR_FACTORY_TEST_A,
			`ADDR_FACTORY_TEST_B,
			`ADDR_TX_COUNT_FIRST,
			`ADDR_TX_COUNT_SECOND:     m = 8'hff;
			default:                   m = 8'h00;
		endcase
		return m;
	endfunction

	function automatic logic in_subset(input reg_addr_t a);
		return (a >= `SUBSET_FIRST) && (a <= `SUBSET_LAST);
	endfunction

	// ==========================================================
	// Storage
	byte_t       regs_reg [0:31];
	byte_t       collision_reg;
	byte_t       fill_reg;
	logic        preset;
	logic        host_wr;
	byte_t       wmask;
	power_if     pwr ();

	assign preset  = !chip_en_i;
	assign wmask   = write_mask(reg_addr_i);
	assign host_wr = reg_wr_i && (wmask != 8'h00);

	// ==========================================================
	// Read-write registers
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < 32; i++) begin
				regs_reg[i] <= preset_value(5'(i));
			end
		end else if (preset) begin
			for (int i = 0; i < 32; i++) begin
				regs_reg[i] <= preset_value(5'(i));
			end
		end else if (host_wr) begin
			if (reg_addr_i == `ADDR_PROTOCOL_SELECT) begin
				for (int i = 0; i < 32; i++) begin
					if (in_subset(5'(i))) begin
						regs_reg[i] <= preset_value(5'(i));
					end
				end
				regs_reg[`ADDR_MOD_CLKOUT_CTRL] <=
					(preset_value(`ADDR_MOD_CLKOUT_CTRL) & ~`MOD_CLKDIV_MASK) |
					(regs_reg[`ADDR_MOD_CLKOUT_CTRL] & `MOD_CLKDIV_MASK);
			end
			regs_reg[reg_addr_i] <= reg_wdata_i & wmask;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			subset_reload_o <= 1'b0;
		end else begin
			subset_reload_o <= !preset && host_wr &&
				(reg_addr_i == `ADDR_PROTOCOL_SELECT);
		end
	end

	// ==========================================================
	// Read-only status registers; a load in the clear cycle wins
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			collision_reg <= `RST_ZERO;
		end else if (collision_load_i) begin
			collision_reg <= collision_pos_i;
		end else if (fifo_reset_i || preset) begin
			collision_reg <= `RST_ZERO;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fill_reg <= `RST_ZERO;
		end else if (fill_load_i) begin
			fill_reg <= fill_state_i;
		end else if (fifo_reset_i || preset) begin
			fill_reg <= `RST_ZERO;
		end
	end

	// ==========================================================
	// Host read path
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			reg_rdata_o  <= `RST_ZERO;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) begin
				unique case (reg_addr_i)
					`ADDR_INTERRUPT_FLAGS:    reg_rdata_o <= irq_flags_i;
					`ADDR_SIGNAL_LEVEL_OSC:   reg_rdata_o <= signal_level_i;
					`ADDR_COLLISION_LOCATION: reg_rdata_o <= collision_reg;
					`ADDR_QUEUE_FILL_STATE:   reg_rdata_o <= fill_reg;
					`ADDR_QUEUE_DATA_PORT:    reg_rdata_o <= fifo_rdata_i;
					default: reg_rdata_o <= regs_reg[reg_addr_i] & write_mask(reg_addr_i);
				endcase
			end
		end
	end

	// ==========================================================
	// FIFO data port
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fifo_wr_o    <= 1'b0;
			fifo_rd_o    <= 1'b0;
			fifo_wdata_o <= `RST_ZERO;
		end else begin
			fifo_wr_o <= reg_wr_i && !preset && (reg_addr_i == `ADDR_QUEUE_DATA_PORT);
			fifo_rd_o <= reg_rd_i && !preset && (reg_addr_i == `ADDR_QUEUE_DATA_PORT);
			if (reg_wr_i && (reg_addr_i == `ADDR_QUEUE_DATA_PORT)) begin
				fifo_wdata_o <= reg_wdata_i;
			end
		end
	end

	// ==========================================================
	// Power and RF control outputs
	byte_t prc;
	logic  direct_variant;
	assign prc            = regs_reg[`ADDR_POWER_RF_CONTROL];
	assign direct_variant = regs_reg[`ADDR_PROTOCOL_SELECT][`PSEL_DIRECT_VARIANT_BIT];
	assign pwr.standby    = standby_o;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			standby_o       <= 1'b0;
			osc_run_o       <= 1'b0;
			regulators_on_o <= 1'b0;
		end else begin
			standby_o       <= prc[`PRC_STANDBY_BIT];
			// Oscillator and regulators stay up in standby for a fast wake
			osc_run_o       <= chip_en_i;
			regulators_on_o <= chip_en_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			frame_mode_o <= FRAME_AUTO;
		end else if (!prc[`PRC_DIRECT_BIT]) begin
			frame_mode_o <= FRAME_AUTO;
		end else begin
			// Variant bit is read live every cycle, so a change while direct takes effect on the next clock edge
			frame_mode_o <= direct_variant ? FRAME_CUSTOM : FRAME_RAW_AFE;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_enable_o     <= 1'b0;
			rx_enable_o     <= 1'b0;
			tx_osc_enable_o <= 1'b0;
		end else begin
			tx_enable_o     <= prc[`PRC_CARRIER_ON_BIT];
			rx_enable_o     <= prc[`PRC_CARRIER_ON_BIT] | prc[`PRC_FORCED_RX_BIT];
			tx_osc_enable_o <= prc[`PRC_CARRIER_ON_BIT] | prc[`PRC_FORCED_RX_BIT];
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			output_power_half_o <= 1'b0;
			aux_input_select_o  <= 1'b0;
			supply_range_sel_o  <= 1'b1;
		end else begin
			output_power_half_o <= prc[`PRC_POWER_HALF_BIT];
			aux_input_select_o  <= prc[`PRC_AUX_INPUT_BIT];
			supply_range_sel_o  <= prc[`PRC_SUPPLY_RANGE_BIT];
		end
	end

	// ==========================================================
	// Standby exit timing
	wake_timer #(
		.WAKE_CYCLES (WAKE_CYCLES)
	) u_wake_timer (
		.clk_sys_i (clk_sys_i),
		.rstn_i    (rstn_i),
		.preset_i  (preset),
		.pwr       (pwr)
	);

	assign full_op_ready_o = pwr.ready;

endmodule
`default_nettype wire

// file: sim/regmap_checker.sv
// Purpose: Port-level assertions for the reader register bank
// Assumes: WAKE_CYCLES equals the value given to the bound design
// Notes:   Bound into reader_regmap below the module
`timescale 1ns/100ps
`default_nettype none
module regmap_checker #(
	parameter int unsigned WAKE_CYCLES = 16
) (
	input wire logic                    clk_sys_i,
	input wire logic                    rstn_i,
	input wire logic                    chip_en_i,
	input wire regmap_pkg::reg_addr_t   reg_addr_i,
	input wire regmap_pkg::byte_t       reg_wdata_i,
	input wire logic                    reg_wr_i,
	input wire logic                    reg_rd_i,
	input wire regmap_pkg::byte_t       reg_rdata_o,
	input wire logic                    reg_rvalid_o,
	input wire regmap_pkg::byte_t       irq_flags_i,
	input wire logic                    subset_reload_o,
	input wire logic                    standby_o,
	input wire logic                    full_op_ready_o,
	input wire logic                    osc_run_o,
	input wire logic                    regulators_on_o,
	input wire regmap_pkg::frame_mode_e frame_mode_o,
	input wire logic                    tx_enable_o,
	input wire logic                    rx_enable_o,
	input wire logic                    tx_osc_enable_o,
	input wire logic                    output_power_half_o,
	input wire logic                    aux_input_select_o,
	input wire logic                    supply_range_sel_o
);
	import regmap_pkg::*;
	int unsigned wake_cnt;
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (!rstn_i);

	// ==========================================================
	// Cycles spent active while full operation is not yet reported
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i)
			wake_cnt <= 0;
		else if (standby_o || full_op_ready_o || !chip_en_i)
			wake_cnt <= 0;
		else
			wake_cnt <= wake_cnt + 1;
	end

	sequence s_ctl_write;
		(reg_wr_i && reg_addr_i == 5'h00 && chip_en_i) ##1 chip_en_i;
	endsequence
	sequence s_preset;
		!chip_en_i [*2];
	endsequence

	property p_preset;
		s_preset |=> supply_range_sel_o && !tx_enable_o && !rx_enable_o && !standby_o;
	endproperty
	property p_carrier;
		s_ctl_write |=> tx_enable_o == $past(reg_wdata_i[5], 2)
			&& rx_enable_o == |($past(reg_wdata_i, 2) & 8'h22);
	endproperty
	property p_power;
		s_ctl_write |=> output_power_half_o == $past(reg_wdata_i[4], 2);
	endproperty
	property p_aux;
		s_ctl_write |=> aux_input_select_o == $past(reg_wdata_i[3], 2);
	endproperty
	property p_forced;
		s_ctl_write |=> tx_osc_enable_o == |($past(reg_wdata_i, 2) & 8'h22);
	endproperty
	property p_supply;
		s_ctl_write |=> supply_range_sel_o == $past(reg_wdata_i[0], 2);
	endproperty
	property p_frame;
		s_ctl_write |=> (frame_mode_o == FRAME_AUTO) == !$past(reg_wdata_i[6], 2);
	endproperty
	property p_standby_run;
		standby_o && chip_en_i && $past(chip_en_i) |-> osc_run_o && regulators_on_o;
	endproperty
	property p_sleep;
		$rose(standby_o) |-> ##[0:1] !full_op_ready_o;
	endproperty
	property p_wake;
		wake_cnt <= WAKE_CYCLES + 4;
	endproperty
	property p_live_read;
		reg_rd_i && reg_addr_i == 5'h0c |=> reg_rvalid_o && reg_rdata_o == $past(irq_flags_i);
	endproperty
	property p_subset;
		reg_wr_i && reg_addr_i == 5'h01 && chip_en_i |=> subset_reload_o;
	endproperty

	a_preset: assert property (p_preset) else $error("control outputs not preset");
	a_carrier: assert property (p_carrier) else $error("carrier enables wrong");
	a_power: assert property (p_power) else $error("power select wrong");
	a_aux: assert property (p_aux) else $error("input select wrong");
	a_forced: assert property (p_forced) else $error("forced receiver wrong");
	a_supply: assert property (p_supply) else $error("supply range wrong");
	a_frame: assert property (p_frame) else $error("framing mode wrong");
	a_standby_run: assert property (p_standby_run) else $error("clock stopped");
	a_sleep: assert property (p_sleep) else $error("ready kept in standby");
	a_wake: assert property (p_wake) else $error("wake too slow");
	a_live_read: assert property (p_live_read) else $error("flag read wrong");
	a_subset: assert property (p_subset) else $error("no subset reload");
endmodule

bind reader_regmap regmap_checker #(.WAKE_CYCLES(WAKE_CYCLES)) u_checker (
	.clk_sys_i, .rstn_i, .chip_en_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
	.reg_rdata_o, .reg_rvalid_o, .irq_flags_i, .subset_reload_o, .standby_o,
	.full_op_ready_o, .osc_run_o, .regulators_on_o, .frame_mode_o, .tx_enable_o,
	.rx_enable_o, .tx_osc_enable_o, .output_power_half_o, .aux_input_select_o,
	.supply_range_sel_o
);
`default_nettype wire

// file: sim/host_model.sv
// Purpose: Host controller issuing byte register accesses
// Assumes: One strobe cycle per access, answer one cycle after a read
// Notes:   Released address and data show the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
module host_model (
	input  wire logic                clk_sys_i,
	output var  regmap_pkg::reg_addr_t reg_addr_o,
	output var  regmap_pkg::byte_t   reg_wdata_o,
	output logic                     reg_wr_o,
	output logic                     reg_rd_o,
	input  wire logic                reg_rvalid_i,
	input  wire regmap_pkg::byte_t   reg_rdata_i
);
	import regmap_pkg::*;
	bit timed_out;
	initial begin
		reg_addr_o = 5'h00;
		reg_wdata_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
	end

	// ==========================================================
	// Bus cycles
	task automatic wr(input reg_addr_t a, input byte_t d);
		@(posedge clk_sys_i);
		reg_addr_o <= a;
		reg_wdata_o <= d;
		reg_wr_o <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_o <= 1'b0;
		reg_addr_o <= ~a;
		reg_wdata_o <= ~d;
	endtask

	task automatic rd(input reg_addr_t a, output byte_t d);
		int n;
		@(posedge clk_sys_i);
		reg_addr_o <= a;
		reg_rd_o <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_o <= 1'b0;
		reg_addr_o <= ~a;
		d = 8'hxx;
		for (n = 0; n < 4; n++) begin
			#1;
			if (reg_rvalid_i === 1'b1) begin
				d = reg_rdata_i;
				break;
			end
			@(posedge clk_sys_i);
		end
		timed_out = (n == 4);
	endtask

	// Variant bit goes in before the direct bit is set
	task automatic enter_direct(input logic variant, input byte_t ctl);
		wr(5'h01, {1'b0, variant, 6'h02});
		wr(5'h00, ctl | 8'h40);
	endtask
endmodule
`default_nettype wire

// file: sim/tb.sv
// Purpose: Self-checking bench for the reader register bank
// Assumes: Shortened wake count of 16 cycles
// Notes:   Mirror array m holds the expected register contents
`timescale 1ns/100ps
`default_nettype none
module tb;
	import regmap_pkg::*;
	localparam int unsigned WAKE = 16;
	logic        clk, rstn, chip_en, wr_s, rd_s, cload, fload, freset;
	logic        rvalid, fifo_wr, fifo_rd, reload, standby, ready, osc, regs;
	logic        tx, rx, txo, half, aux, sup;
	reg_addr_t   addr;
	byte_t       wdata, rdata, irq, sig, cpos, fill, fhead, fifo_wdata, d;
	frame_mode_e frame;
	int          fail_count, checked;
	byte_t       m[32];
	byte_t       pre[32] = '{0: 8'h01, 1: 8'h02, 4: 8'hc1, 5: 8'hc1, 7: 8'h0e, 8: 8'h07,
		9: 8'h91, 10: 8'h10, 11: 8'h87, 13: 8'h3e, default: 8'h00};

	reader_regmap #(.WAKE_CYCLES(WAKE)) dut (
		.clk_sys_i(clk), .rstn_i(rstn), .chip_en_i(chip_en), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
		.reg_rvalid_o(rvalid), .irq_flags_i(irq), .signal_level_i(sig),
		.collision_pos_i(cpos), .collision_load_i(cload), .fill_state_i(fill),
		.fill_load_i(fload), .fifo_reset_i(freset), .fifo_rdata_i(fhead),
		.fifo_wr_o(fifo_wr), .fifo_rd_o(fifo_rd), .fifo_wdata_o(fifo_wdata),
		.subset_reload_o(reload), .standby_o(standby), .full_op_ready_o(ready),
		.osc_run_o(osc), .regulators_on_o(regs), .frame_mode_o(frame), .tx_enable_o(tx),
		.rx_enable_o(rx), .tx_osc_enable_o(txo), .output_power_half_o(half),
		.aux_input_select_o(aux), .supply_range_sel_o(sup)
	);
	host_model host (
		.clk_sys_i(clk), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr_s),
		.reg_rd_o(rd_s), .reg_rvalid_i(rvalid), .reg_rdata_i(rdata)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ==========================================================
	// Expectations
	function automatic byte_t wmask(input int a);
		case (a)
			0: return 8'hfb;
			1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 13, 16, 17, 20, 26, 27, 29, 30: return 8'hff;
			default: return 8'h00;
		endcase
	endfunction
	function automatic byte_t expect_rd(input int a);
		case (a)
			12: return irq;
			15: return sig;
			31: return fhead;
			default: return m[a];
		endcase
	endfunction
	function automatic logic [8:0] exp_ctl();
		byte_t c;
		c = m[0];
		return {c[7], c[5], c[5] | c[1], c[5] | c[1], c[4], c[3], c[0],
			c[6] ? (m[1][6] ? FRAME_CUSTOM : FRAME_RAW_AFE) : FRAME_AUTO};
	endfunction

	// ==========================================================
	// Checks and bus helpers
	task automatic stop_test();
		$display("checked=%0d fail_count=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_ctl();
		cmp({standby, tx, rx, txo, half, aux, sup, frame}, exp_ctl());
	endtask
	task automatic wr(input int a, input byte_t v);
		host.wr(a[4:0], v);
		m[a] = (m[a] & ~wmask(a)) | (v & wmask(a));
	endtask
	task automatic rd_chk(input int a);
		host.rd(a[4:0], d);
		if (host.timed_out) begin
			fail_count++;
			stop_test();
		end
		cmp(d, expect_rd(a));
	endtask
	task automatic reload_mirror();
		byte_t k;
		k = m[9];
		for (int a = 2; a < 12; a++)
			m[a] = pre[a];
		m[9] = (pre[9] & 8'hcf) | (k & 8'h30);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		int i, a;
		byte_t v;
		void'($urandom(83681));
		rstn = 1'b0;
		chip_en = 1'b1;
		cload = 1'b0;
		fload = 1'b0;
		freset = 1'b0;
		irq = $urandom;
		sig = $urandom;
		cpos = 8'h00;
		fill = 8'h00;
		fhead = $urandom;
		m = pre;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		for (a = 0; a < 32; a++) rd_chk(a);
		chk_ctl();
		$display("test presets done");
		for (i = 0; i < 60; i++) begin
			a = $urandom_range(30);
			if (a == 1)
				a = 0;
			v = $urandom;
			@(posedge clk);
			irq <= $urandom;
			sig <= $urandom;
			fhead <= $urandom;
			wr(a, v);
			rd_chk(a);
			chk_ctl();
		end
		$display("test random access done");
		wr(9, 8'hff);
		wr(1, $urandom);
		#1;
		cmp(reload, 1'b1);
		reload_mirror();
		for (a = 1; a < 12; a++) rd_chk(a);
		for (i = 0; i < 2; i++) begin
			host.enter_direct(i[0], 8'h21);
			m[1] = {1'b0, i[0], 6'h02};
			m[0] = 8'h61;
			reload_mirror();
			repeat (2) @(posedge clk);
			#1;
			chk_ctl();
		end
		$display("test protocol and direct done");
		@(posedge clk);
		cpos <= $urandom;
		fill <= $urandom;
		cload <= 1'b1;
		fload <= 1'b1;
		@(posedge clk);
		cload <= 1'b0;
		fload <= 1'b0;
		m[14] = cpos;
		m[28] = fill;
		wr(14, 8'hff);
		wr(28, 8'hff);
		rd_chk(14);
		rd_chk(28);
		@(posedge clk);
		freset <= 1'b1;
		@(posedge clk);
		freset <= 1'b0;
		m[14] = 8'h00;
		m[28] = 8'h00;
		rd_chk(14);
		rd_chk(28);
		$display("test status registers done");
		v = $urandom;
		host.wr(5'h1f, v);
		#1;
		cmp({fifo_wr, fifo_wdata}, {1'b1, v});
		rd_chk(31);
		cmp(fifo_rd, 1'b1);
		$display("test data port done");
		wr(0, 8'h81);
		repeat (3) @(posedge clk);
		#1;
		cmp({standby, osc, regs, ready}, 4'b1110);
		wr(0, 8'h01);
		// Look past the edge so the flop update is settled
		for (i = 0; i < WAKE + 20 && ready !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		cmp(ready, 1'b1);
		cmp(i <= WAKE + 6, 1'b1);
		if (ready !== 1'b1)
			stop_test();
		$display("test standby done");
		wr(16, 8'h5a);
		wr(0, 8'h3a);
		@(posedge clk);
		chip_en <= 1'b0;
		host.wr(5'h10, 8'hff);
		chip_en <= 1'b1;
		m = pre;
		for (a = 0; a < 32; a++) rd_chk(a);
		chk_ctl();
		$display("test enable preset done");
		stop_test();
	end
endmodule
`default_nettype wire
